// file: pvm_cnt_if.sv
// Event, clear and count of one saturating counter.
`timescale 1ns/1ns
interface pvm_cnt_if;
	logic evt;
	logic clr;
	logic [15:0] count;
	modport cnt (input evt, input clr, output count);
	modport src (output evt);
	modport ctl (output clr, input count);
endinterface : pvm_cnt_if

// file: pvm_mgmt_model.sv
// Management controller model driving the strobed register port.
`timescale 1ns/1ns
module pvm_mgmt_model
	import pvm_pkg::*;
(
	input wire logic clk,
	output logic [pvm_pkg::ADDR_W-1:0] mgmt_addr,
	output logic mgmt_wr,
	output logic mgmt_rd,
	output logic [15:0] mgmt_wdata
);
	initial begin
		mgmt_addr = 5'h00;
		mgmt_wr = 1'b0;
		mgmt_rd = 1'b0;
		mgmt_wdata = 16'h0000;
	end

	// One strobe cycle per access, then a free edge before the next
	task automatic access(input logic wr, input logic [4:0] addr, input logic [15:0] data);
		@(posedge clk);
		mgmt_addr <= addr;
		mgmt_wdata <= data;
		mgmt_wr <= wr;
		mgmt_rd <= ~wr;
		@(posedge clk);
		mgmt_wr <= 1'b0;
		mgmt_rd <= 1'b0;
		// Released lines stop showing the last value
		mgmt_addr <= ~addr;
		mgmt_wdata <= ~data;
	endtask : access
endmodule : pvm_mgmt_model

// file: pvm_pkg.sv
// Constants shared by the PHY vendor management register bank.
package pvm_pkg;
	localparam int CNT_W = 16;
	localparam int ADDR_W = 5;
	localparam int NUM_CNT = 4;

	// Register numbers on the management register port
	localparam logic [4:0] ADDR_STATUS_CTRL = 5'h10;
	localparam logic [4:0] ADDR_SPECIAL_CTRL = 5'h11;
	localparam logic [4:0] ADDR_PHY_ADDRESS = 5'h12;
	localparam logic [4:0] ADDR_FALSE_CARRIER = 5'h13;
	localparam logic [4:0] ADDR_DISCONNECT = 5'h14;
	localparam logic [4:0] ADDR_ERROR_FRAME = 5'h15;
	localparam logic [4:0] ADDR_SYMBOL_ERROR = 5'h16;

	// Counter slots
	localparam int CNT_FALSE_CARRIER = 0;
	localparam int CNT_DISCONNECT = 1;
	localparam int CNT_ERROR_FRAME = 2;
	localparam int CNT_SYMBOL_ERROR = 3;

	// Status and control register fields
	localparam int SC_RSVD_HI = 15;
	localparam int SC_CSD_BIT = 13;
	localparam int SC_TFC_BIT = 12;
	localparam int SC_SYNC_BIT = 11;
	localparam int SC_PD100_BIT = 10;
	localparam int SC_PD10_BIT = 9;
	localparam int SC_POL_BIT = 8;
	localparam int SC_SPEED_BIT = 1;
	localparam int SC_DUPLEX_BIT = 0;

	// Reset values, read constants and counter limits
	localparam logic [3:0] SC_CTRL_RESET = 4'h0;
	localparam logic [5:0] STAT_CAP_RESET = 6'h18;
	localparam logic [15:0] SPC_RESET = 16'h0000;
	localparam logic [15:0] PHY_ADDR_VALUE = 16'h0001;
	localparam logic [15:0] CNT_MAX = 16'hffff;
	localparam logic [15:0] CNT_ONE = 16'h0001;
	localparam logic [15:0] RDATA_ZERO = 16'h0000;

	// Consecutive bad symbols folded into one count
	localparam logic [2:0] SYM_RUN_LAST = 3'h5;
endpackage : pvm_pkg

// file: pvm_regs.sv
// Vendor management registers 16 to 22 of the Fast Ethernet PHY.
`timescale 1ns/1ns
// Functional notes
// - Status-control bit 13 enables carrier sense disconnect; resets to zero.
// - Status-control bit 12 set enables transmit flow control; resets to zero.
// - Read-only bit 11 shows 100 Mbit de-serializer in sync.
// - Bits 10 and 9 show 100 and 10 Mbit power-down; both reset one.
// - Bit 8 shows 10 Mbit receive polarity reversed.
// - Bit 1 shows 100 Mbps result, bit 0 full duplex result.
// - Special-control bit 15 bypasses the scrambler; resets zero.
// - Special-control bit 14 bypasses 4B/5B encoding; resets zero.
// - Bit 13 forces H pattern, bit 12 forces 34 pattern.
// - Bit 11 forces 100 Mbit link good; resets zero.
// - Bit 9 disables transmit carrier sense; resets zero.
// - Bit 8 disables dynamic power-down; clear keeps it enabled.
// - Bit 7 puts auto-negotiation into loopback.
// - Bit 6 tri-states line transmit drivers; resets zero.
// - Bit 5 bypasses receive filter, bit 4 disables auto polarity.
// - Bit 3 disables squelch test, bit 2 enables extended squelch.
// - Bit 1 disables link integrity, bit 0 disables jabber.
// - PHY address register reads 00001b, upper bits zero, ignores writes.
// - False carrier count is read-only, cleared by reading it.
// - Disconnect count increments per event, saturates, clears on read.
// - Error frame count increments once per errored frame, saturates, clears on read.
// - Symbol error count counts each six consecutive bad symbols once.
module pvm_regs
	import pvm_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [pvm_pkg::ADDR_W-1:0] mgmt_addr,
	input wire logic mgmt_wr,
	input wire logic mgmt_rd,
	input wire logic [15:0] mgmt_wdata,
	output logic [15:0] mgmt_rdata,
	output logic mgmt_rvalid,
	input wire logic deser_in_sync,
	input wire logic pd_100,
	input wire logic pd_10,
	input wire logic pol_reversed,
	input wire logic an_speed_100,
	input wire logic an_full_duplex,
	input wire logic false_carrier_evt,
	input wire logic disconnect_evt,
	input wire logic rx_frame_active,
	input wire logic rx_sym_valid,
	input wire logic rx_sym_err,
	input wire logic rx_premature_end,
	output logic cs_disconnect_en,
	output logic tx_flow_ctrl_en,
	output logic scrambler_bypass,
	output logic enc_bypass,
	output logic force_h_pattern,
	output logic force_34_pattern,
	output logic force_link_good,
	output logic tx_cs_disable,
	output logic dyn_pd_disable,
	output logic an_loopback,
	output logic line_tristate,
	output logic rx_filter_bypass,
	output logic auto_pol_disable,
	output logic squelch_disable,
	output logic ext_squelch_en,
	output logic link_integrity_disable,
	output logic jabber_disable
);
	import pvm_pkg::*;

	logic [1:0] rst_sync_q;
	logic rst_int_n;
	logic [3:0] sc_ctrl_q;
	logic [5:0] stat_q;
	logic [15:0] spc_q;
	logic [15:0] rdata_q;
	logic rvalid_q;
	logic [15:0] rd_value;
	logic [5:0] stat_in;

	pvm_cnt_if cnt_if [NUM_CNT] ();

	// Reset released through two flops
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rst_sync_q <= 2'h0;
		end else begin
			rst_sync_q <= {rst_sync_q[0], 1'b1};
		end
	end
	assign rst_int_n = rst_sync_q[1];

	// Writable bits 15:12 of the status and control register
	always_ff @(posedge clk or negedge rst_int_n) begin
		if (!rst_int_n) begin
			sc_ctrl_q <= SC_CTRL_RESET;
		end else if (mgmt_wr && mgmt_addr == ADDR_STATUS_CTRL) begin
			sc_ctrl_q <= mgmt_wdata[SC_RSVD_HI:SC_TFC_BIT];
		end
	end

	assign stat_in = {deser_in_sync, pd_100, pd_10, pol_reversed, an_speed_100, an_full_duplex};

	// Live PHY state, captured every cycle
	always_ff @(posedge clk or negedge rst_int_n) begin
		if (!rst_int_n) begin
			stat_q <= STAT_CAP_RESET;
		end else begin
			stat_q <= stat_in;
		end
	end

	// Special control register
	always_ff @(posedge clk or negedge rst_int_n) begin
		if (!rst_int_n) begin
			spc_q <= SPC_RESET;
		end else if (mgmt_wr && mgmt_addr == ADDR_SPECIAL_CTRL) begin
			spc_q <= mgmt_wdata;
		end
	end

	// Receive error events feed the two frame-based counters
	pvm_rx_err_qual u_qual (
		.clk(clk),
		.rst_n(rst_int_n),
		.rx_frame_active(rx_frame_active),
		.rx_sym_valid(rx_sym_valid),
		.rx_sym_err(rx_sym_err),
		.rx_premature_end(rx_premature_end),
		.frame_if(cnt_if[CNT_ERROR_FRAME]),
		.sym_if(cnt_if[CNT_SYMBOL_ERROR])
	);

	assign cnt_if[CNT_FALSE_CARRIER].evt = false_carrier_evt;
	assign cnt_if[CNT_DISCONNECT].evt = disconnect_evt;

	// Reading a counter register clears that counter
	assign cnt_if[CNT_FALSE_CARRIER].clr = mgmt_rd && mgmt_addr == ADDR_FALSE_CARRIER;
	assign cnt_if[CNT_DISCONNECT].clr = mgmt_rd && mgmt_addr == ADDR_DISCONNECT;
	assign cnt_if[CNT_ERROR_FRAME].clr = mgmt_rd && mgmt_addr == ADDR_ERROR_FRAME;
	assign cnt_if[CNT_SYMBOL_ERROR].clr = mgmt_rd && mgmt_addr == ADDR_SYMBOL_ERROR;

	for (genvar g = 0; g < NUM_CNT; g++) begin : g_cnt
		pvm_sat_counter u_cnt (
			.clk(clk),
			.rst_n(rst_int_n),
			.bus(cnt_if[g])
		);
	end

	// Read multiplexer; unmapped numbers read zero
	always_comb begin
		rd_value = RDATA_ZERO;
		if (mgmt_addr == ADDR_STATUS_CTRL) begin
			rd_value = {sc_ctrl_q, stat_q[5:2], 6'h00, stat_q[1:0]};
		end else if (mgmt_addr == ADDR_SPECIAL_CTRL) begin
			rd_value = spc_q;
		end else if (mgmt_addr == ADDR_PHY_ADDRESS) begin
			rd_value = PHY_ADDR_VALUE;
		end else if (mgmt_addr == ADDR_FALSE_CARRIER) begin
			rd_value = cnt_if[CNT_FALSE_CARRIER].count;
		end else if (mgmt_addr == ADDR_DISCONNECT) begin
			rd_value = cnt_if[CNT_DISCONNECT].count;
		end else if (mgmt_addr == ADDR_ERROR_FRAME) begin
			rd_value = cnt_if[CNT_ERROR_FRAME].count;
		end else if (mgmt_addr == ADDR_SYMBOL_ERROR) begin
			rd_value = cnt_if[CNT_SYMBOL_ERROR].count;
		end
	end

	always_ff @(posedge clk or negedge rst_int_n) begin
		if (!rst_int_n) begin
			rdata_q <= RDATA_ZERO;
		end else if (mgmt_rd) begin
			rdata_q <= rd_value;
		end
	end

	always_ff @(posedge clk or negedge rst_int_n) begin
		if (!rst_int_n) begin
			rvalid_q <= 1'b0;
		end else begin
			rvalid_q <= mgmt_rd;
		end
	end

	assign mgmt_rdata = rdata_q;
	assign mgmt_rvalid = rvalid_q;

	// Control outputs straight from the register flops
	assign cs_disconnect_en = sc_ctrl_q[SC_CSD_BIT-SC_TFC_BIT];
	assign tx_flow_ctrl_en = sc_ctrl_q[0];
	assign scrambler_bypass = spc_q[15];
	assign enc_bypass = spc_q[14];
	assign force_h_pattern = spc_q[13];
	assign force_34_pattern = spc_q[12];
	assign force_link_good = spc_q[11];
	assign tx_cs_disable = spc_q[9];
	assign dyn_pd_disable = spc_q[8];
	assign an_loopback = spc_q[7];
	assign line_tristate = spc_q[6];
	assign rx_filter_bypass = spc_q[5];
	assign auto_pol_disable = spc_q[4];
	assign squelch_disable = spc_q[3];
	assign ext_squelch_en = spc_q[2];
	assign link_integrity_disable = spc_q[1];
	assign jabber_disable = spc_q[0];

	// Checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_int_n);

	logic bad_in;
	assign bad_in = rx_frame_active && rx_sym_valid && rx_sym_err;

	sequence s_sc_write;
		mgmt_wr && mgmt_addr == ADDR_STATUS_CTRL;
	endsequence

	sequence s_spc_write;
		mgmt_wr && mgmt_addr == ADDR_SPECIAL_CTRL;
	endsequence

	sequence s_sc_read;
		mgmt_rd && !mgmt_wr && mgmt_addr == ADDR_STATUS_CTRL;
	endsequence

	property p_csd_follow;
		s_sc_write |=> cs_disconnect_en == $past(mgmt_wdata[SC_CSD_BIT]);
	endproperty
	a_csd_follow: assert property (p_csd_follow) else $error("disconnect enable wrong");

	property p_tfc_follow;
		s_sc_write |=> tx_flow_ctrl_en == $past(mgmt_wdata[SC_TFC_BIT]);
	endproperty
	a_tfc_follow: assert property (p_tfc_follow) else $error("flow control enable wrong");

	property p_status_read;
		s_sc_read ##1 1'b1 |-> mgmt_rvalid && mgmt_rdata[SC_SYNC_BIT:SC_POL_BIT] ==
			$past(stat_in[5:2], 2) && mgmt_rdata[1:0] == $past(stat_in[1:0], 2);
	endproperty
	a_status_read: assert property (p_status_read) else $error("status bits wrong");

	property p_spc_write;
		s_spc_write |=> {scrambler_bypass, enc_bypass, force_h_pattern, force_34_pattern,
			force_link_good, tx_cs_disable, dyn_pd_disable, an_loopback, line_tristate,
			rx_filter_bypass, auto_pol_disable, squelch_disable, ext_squelch_en,
			link_integrity_disable, jabber_disable} ==
			{$past(mgmt_wdata[15:11]), $past(mgmt_wdata[9:0])};
	endproperty
	a_spc_write: assert property (p_spc_write) else $error("special control wrong");

	property p_spc_hold;
		!(mgmt_wr && mgmt_addr == ADDR_SPECIAL_CTRL) |=> $stable(spc_q);
	endproperty
	a_spc_hold: assert property (p_spc_hold) else $error("special control changed");

	property p_addr_read;
		mgmt_rd && mgmt_addr == ADDR_PHY_ADDRESS |=> mgmt_rdata == PHY_ADDR_VALUE;
	endproperty
	a_addr_read: assert property (p_addr_read) else $error("PHY address wrong");

	property p_fc_clear;
		mgmt_rd && mgmt_addr == ADDR_FALSE_CARRIER && !false_carrier_evt |=>
			cnt_if[CNT_FALSE_CARRIER].count == RDATA_ZERO;
	endproperty
	a_fc_clear: assert property (p_fc_clear) else $error("false carrier not cleared");

	property p_disc_sat;
		cnt_if[CNT_DISCONNECT].count == CNT_MAX && !cnt_if[CNT_DISCONNECT].clr |=>
			cnt_if[CNT_DISCONNECT].count == CNT_MAX;
	endproperty
	a_disc_sat: assert property (p_disc_sat) else $error("disconnect count wrapped");

	property p_disc_inc;
		disconnect_evt && !cnt_if[CNT_DISCONNECT].clr &&
			cnt_if[CNT_DISCONNECT].count != CNT_MAX |=>
			cnt_if[CNT_DISCONNECT].count == $past(cnt_if[CNT_DISCONNECT].count) + CNT_ONE;
	endproperty
	a_disc_inc: assert property (p_disc_inc) else $error("disconnect count missed");

	sequence s_frame_err_then_frame;
		cnt_if[CNT_ERROR_FRAME].evt ##1 rx_frame_active ##1 rx_frame_active;
	endsequence

	property p_frame_once;
		s_frame_err_then_frame |-> !cnt_if[CNT_ERROR_FRAME].evt;
	endproperty
	a_frame_once: assert property (p_frame_once) else $error("frame counted twice");

	sequence s_seven_bad;
		!rx_frame_active ##1 !bad_in ##1 bad_in [*7];
	endsequence

	property p_sym_seven;
		s_seven_bad |=> cnt_if[CNT_SYMBOL_ERROR].evt && !$past(cnt_if[CNT_SYMBOL_ERROR].evt);
	endproperty
	a_sym_seven: assert property (p_sym_seven) else $error("symbol run miscounted");

	property p_clr_evt;
		cnt_if[CNT_DISCONNECT].clr && disconnect_evt |=>
			cnt_if[CNT_DISCONNECT].count == CNT_ONE;
	endproperty
	a_clr_evt: assert property (p_clr_evt) else $error("event lost at clear");

	property p_fc_clr_evt;
		cnt_if[CNT_FALSE_CARRIER].clr && false_carrier_evt |=>
			cnt_if[CNT_FALSE_CARRIER].count == CNT_ONE;
	endproperty
	a_fc_clr_evt: assert property (p_fc_clr_evt) else $error("carrier event lost");

	property p_spc_read;
		mgmt_rd && mgmt_addr == ADDR_SPECIAL_CTRL |=> mgmt_rvalid && mgmt_rdata == $past(spc_q);
	endproperty
	a_spc_read: assert property (p_spc_read) else $error("special control readback wrong");

	property p_ef_clear;
		mgmt_rd && mgmt_addr == ADDR_ERROR_FRAME && !cnt_if[CNT_ERROR_FRAME].evt |=>
			cnt_if[CNT_ERROR_FRAME].count == RDATA_ZERO;
	endproperty
	a_ef_clear: assert property (p_ef_clear) else $error("error frame not cleared");

	property p_sym_clear;
		mgmt_rd && mgmt_addr == ADDR_SYMBOL_ERROR && !cnt_if[CNT_SYMBOL_ERROR].evt |=>
			cnt_if[CNT_SYMBOL_ERROR].count == RDATA_ZERO;
	endproperty
	a_sym_clear: assert property (p_sym_clear) else $error("symbol count not cleared");

	property p_fc_inc;
		false_carrier_evt && !cnt_if[CNT_FALSE_CARRIER].clr &&
			cnt_if[CNT_FALSE_CARRIER].count != CNT_MAX |=>
			cnt_if[CNT_FALSE_CARRIER].count == $past(cnt_if[CNT_FALSE_CARRIER].count) + CNT_ONE;
	endproperty
	a_fc_inc: assert property (p_fc_inc) else $error("false carrier missed");

	property p_sc_hold;
		!(mgmt_wr && mgmt_addr == ADDR_STATUS_CTRL) |=> $stable(sc_ctrl_q);
	endproperty
	a_sc_hold: assert property (p_sc_hold) else $error("status control changed");

	property p_status_rsvd;
		s_sc_read |=> mgmt_rdata[SC_POL_BIT-1:SC_SPEED_BIT+1] == 6'h00;
	endproperty
	a_status_rsvd: assert property (p_status_rsvd) else $error("status reserved bits set");
endmodule : pvm_regs

// file: pvm_rx_err_qual.sv
// Turns receive symbol errors into per-frame and per-run count events.
`timescale 1ns/1ns
module pvm_rx_err_qual
	import pvm_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic rx_frame_active,
	input wire logic rx_sym_valid,
	input wire logic rx_sym_err,
	input wire logic rx_premature_end,
	pvm_cnt_if.src frame_if,
	pvm_cnt_if.src sym_if
);
	logic bad_sym;
	logic frame_err;
	logic seen_q;
	logic [2:0] run_q;
	logic frame_evt_q;
	logic sym_evt_q;

	assign bad_sym = rx_frame_active && rx_sym_valid && rx_sym_err;
	assign frame_err = rx_frame_active && ((rx_sym_valid && rx_sym_err) || rx_premature_end);

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			seen_q <= 1'b0;
		end else if (!rx_frame_active) begin
			seen_q <= 1'b0;
		end else if (frame_err) begin
			seen_q <= 1'b1;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			frame_evt_q <= 1'b0;
		end else begin
			frame_evt_q <= frame_err && !seen_q;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			run_q <= 3'h0;
		end else if (!rx_frame_active || (rx_sym_valid && !rx_sym_err)) begin
			run_q <= 3'h0;
		end else if (bad_sym) begin
			run_q <= (run_q == SYM_RUN_LAST) ? 3'h0 : run_q + 3'h1;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sym_evt_q <= 1'b0;
		end else begin
			sym_evt_q <= bad_sym && run_q == 3'h0;
		end
	end

	assign frame_if.evt = frame_evt_q;
	assign sym_if.evt = sym_evt_q;
endmodule : pvm_rx_err_qual

// file: pvm_sat_counter.sv
// Saturating clear-on-read event counter.
`timescale 1ns/1ns
module pvm_sat_counter
	import pvm_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	pvm_cnt_if.cnt bus
);
	logic [CNT_W-1:0] count_q;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			count_q <= RDATA_ZERO;
		end else if (bus.clr) begin
			// Event during the clearing read survives as one
			count_q <= bus.evt ? CNT_ONE : RDATA_ZERO;
		end else if (bus.evt && count_q != CNT_MAX) begin
			count_q <= count_q + CNT_ONE;
		end
	end

	assign bus.count = count_q;
endmodule : pvm_sat_counter

// file: tb.sv
// Self-checking bench for the vendor management register bank.
`timescale 1ns/1ns
module tb;
	import pvm_pkg::*;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [4:0] mgmt_addr;
	logic mgmt_wr;
	logic mgmt_rd;
	logic [15:0] mgmt_wdata;
	logic [15:0] mgmt_rdata;
	logic mgmt_rvalid;
	logic [5:0] stat = 6'h18;
	logic [3:0] sc_ctrl = 4'h0;
	logic fc_evt = 1'b0;
	logic dc_evt = 1'b0;
	logic frame = 1'b0;
	logic sym_v = 1'b0;
	logic sym_e = 1'b0;
	logic pre_end = 1'b0;
	logic [1:0] sc_o;
	logic [15:0] spc_o;
	logic [15:0] expq[$];
	logic [4:0] addrq[$];
	int unsigned seed = 66;
	int checks = 0;
	int miscompares = 0;
	int cycles = 0;

	always #4 clk = ~clk;

	pvm_mgmt_model mac (.clk(clk), .mgmt_addr(mgmt_addr), .mgmt_wr(mgmt_wr),
		.mgmt_rd(mgmt_rd), .mgmt_wdata(mgmt_wdata));

	pvm_regs dut (.clk(clk), .rst_n(rst_n), .mgmt_addr(mgmt_addr), .mgmt_wr(mgmt_wr),
		.mgmt_rd(mgmt_rd), .mgmt_wdata(mgmt_wdata), .mgmt_rdata(mgmt_rdata),
		.mgmt_rvalid(mgmt_rvalid), .deser_in_sync(stat[5]), .pd_100(stat[4]),
		.pd_10(stat[3]), .pol_reversed(stat[2]), .an_speed_100(stat[1]),
		.an_full_duplex(stat[0]), .false_carrier_evt(fc_evt), .disconnect_evt(dc_evt),
		.rx_frame_active(frame), .rx_sym_valid(sym_v), .rx_sym_err(sym_e),
		.rx_premature_end(pre_end), .cs_disconnect_en(sc_o[1]), .tx_flow_ctrl_en(sc_o[0]),
		.scrambler_bypass(spc_o[15]), .enc_bypass(spc_o[14]), .force_h_pattern(spc_o[13]),
		.force_34_pattern(spc_o[12]), .force_link_good(spc_o[11]), .tx_cs_disable(spc_o[9]),
		.dyn_pd_disable(spc_o[8]), .an_loopback(spc_o[7]), .line_tristate(spc_o[6]),
		.rx_filter_bypass(spc_o[5]), .auto_pol_disable(spc_o[4]),
		.squelch_disable(spc_o[3]), .ext_squelch_en(spc_o[2]),
		.link_integrity_disable(spc_o[1]), .jabber_disable(spc_o[0]));

	function automatic logic [15:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed[15:0];
	endfunction : xs

	function automatic logic [15:0] sc_exp();
		return {sc_ctrl, stat[5:2], 6'h00, stat[1:0]};
	endfunction : sc_exp

	task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
		checks++;
		if (got !== exp) begin
			miscompares++;
			$display("ERROR %s expected %h seen %h", name, exp, got);
		end
	endtask : chk

	task automatic rd(input logic [4:0] addr, input logic [15:0] exp);
		expq.push_back(exp);
		addrq.push_back(addr);
		mac.access(1'b0, addr, 16'h0000);
	endtask : rd

	task automatic results();
		$display("Checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : results

	// Each read answer is matched against the oldest note
	always @(negedge clk) begin
		if (mgmt_rvalid === 1'b1) begin
			if (expq.size() == 0) begin
				miscompares++;
				$display("ERROR rdata expected none seen %h", mgmt_rdata);
			end else begin
				chk($sformatf("rdata of reg %h", addrq.pop_front()), expq.pop_front(), mgmt_rdata);
			end
		end
	end

	always @(posedge clk) begin
		cycles++;
		if (cycles == 90000) begin
			miscompares++;
			results();
		end
	end

	initial begin
		logic [15:0] d;
		logic [15:0] r;
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		repeat (4) @(posedge clk);
		rd(ADDR_SPECIAL_CTRL, 16'h0000);
		rd(ADDR_STATUS_CTRL, sc_exp());
		chk("control outputs", 16'h0000, {spc_o[15:11], 1'b0, spc_o[9:0]});
		chk("status control outputs", 16'h0000, {14'h0000, sc_o});
		for (int a = 19; a <= 22; a++) begin
			rd(a[4:0], 16'h0000);
		end
		mac.access(1'b1, ADDR_PHY_ADDRESS, 16'hffff);
		rd(ADDR_PHY_ADDRESS, 16'h0001);
		mac.access(1'b1, 5'h05, 16'hffff);
		rd(5'h05, 16'h0000);
		// Random control words, first one all ones
		for (int i = 0; i < 8; i++) begin
			d = (i == 0) ? 16'hffff : xs();
			mac.access(1'b1, ADDR_SPECIAL_CTRL, d);
			@(negedge clk);
			chk("control outputs", d & 16'hfbff, {spc_o[15:11], 1'b0, spc_o[9:0]});
			rd(ADDR_SPECIAL_CTRL, d);
			r = xs();
			mac.access(1'b1, ADDR_STATUS_CTRL, r);
			sc_ctrl = r[15:12];
			r = xs();
			stat <= r[5:0];
			@(negedge clk);
			chk("status control outputs", {14'h0000, sc_ctrl[1:0]}, {14'h0000, sc_o});
			repeat (3) @(posedge clk);
			rd(ADDR_STATUS_CTRL, sc_exp());
		end
		for (int i = 0; i < 3; i++) begin
			@(posedge clk);
			fc_evt <= 1'b1;
			@(posedge clk);
			fc_evt <= 1'b0;
		end
		repeat (2) @(posedge clk);
		rd(ADDR_FALSE_CARRIER, 16'h0003);
		rd(ADDR_FALSE_CARRIER, 16'h0000);
		// Event lands on the clearing read edge
		fork
			rd(ADDR_FALSE_CARRIER, 16'h0000);
			begin
				@(posedge clk);
				fc_evt <= 1'b1;
				@(posedge clk);
				fc_evt <= 1'b0;
			end
		join
		repeat (2) @(posedge clk);
		rd(ADDR_FALSE_CARRIER, 16'h0001);
		// Saturate, then read while the event is still high
		@(posedge clk);
		dc_evt <= 1'b1;
		repeat (65537) @(posedge clk);
		rd(ADDR_DISCONNECT, 16'hffff);
		dc_evt <= 1'b0;
		repeat (2) @(posedge clk);
		rd(ADDR_DISCONNECT, 16'h0001);
		rd(ADDR_DISCONNECT, 16'h0000);
		// Frame one: seven bad symbols in a row
		@(posedge clk);
		frame <= 1'b1;
		repeat (7) begin
			@(posedge clk);
			sym_v <= 1'b1;
			sym_e <= 1'b1;
		end
		@(posedge clk);
		sym_v <= 1'b0;
		sym_e <= 1'b0;
		frame <= 1'b0;
		// Frame two: early end, good symbol, five bad with a gap
		@(posedge clk);
		frame <= 1'b1;
		pre_end <= 1'b1;
		@(posedge clk);
		pre_end <= 1'b0;
		sym_v <= 1'b1;
		for (int i = 0; i < 6; i++) begin
			@(posedge clk);
			sym_v <= (i != 3);
			sym_e <= 1'b1;
		end
		@(posedge clk);
		sym_v <= 1'b0;
		sym_e <= 1'b0;
		frame <= 1'b0;
		repeat (4) @(posedge clk);
		rd(ADDR_ERROR_FRAME, 16'h0002);
		rd(ADDR_SYMBOL_ERROR, 16'h0003);
		rd(ADDR_ERROR_FRAME, 16'h0000);
		rd(ADDR_SYMBOL_ERROR, 16'h0000);
		repeat (4) @(posedge clk);
		if (expq.size() != 0) begin
			miscompares++;
			$display("ERROR pending reads expected 0 seen %0d", expq.size());
		end
		results();
	end
endmodule : tb
